// File: shared/dls_pkg.sv
// Package: register map, field positions and frame constants for the startup config block
package dls_pkg;

  localparam int AW = 15;
  localparam int DW = 8;

  // Serial frame layout
  localparam int INST_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int RW_POS    = 14;  // Read flag position after 15 shifts

  // Directly mapped registers, read/write except the read-only PLL status, SERDES PLL status and temperature code
  localparam logic [14:0] A_IFCFG = 15'h000;
  localparam logic [14:0] A_PWR   = 15'h011;
  localparam logic [14:0] A_CLKPD = 15'h080;
  localparam logic [14:0] A_SREF  = 15'h081;
  localparam logic [14:0] A_PLLEN = 15'h083;
  localparam logic [14:0] A_PLLST = 15'h084;
  localparam logic [14:0] A_FBCNT = 15'h085;
  localparam logic [14:0] A_VCODV = 15'h08b;
  localparam logic [14:0] A_REFDV = 15'h08c;
  localparam logic [14:0] A_FMT   = 15'h110;
  localparam logic [14:0] A_INTP  = 15'h112;
  localparam logic [14:0] A_TEN   = 15'h12f;
  localparam logic [14:0] A_TLO   = 15'h132;
  localparam logic [14:0] A_THI   = 15'h133;
  localparam logic [14:0] A_TCAP  = 15'h134;
  localparam logic [14:0] A_SIPD  = 15'h200;
  localparam logic [14:0] A_LNPD  = 15'h201;
  localparam logic [14:0] A_SPLEN = 15'h280;
  localparam logic [14:0] A_SPLST = 15'h281;
  localparam logic [14:0] A_LCTL  = 15'h300;
  // Link parameter registers, one page per link
  localparam logic [14:0] A_DID   = 15'h450;
  localparam logic [14:0] A_BID   = 15'h451;
  localparam logic [14:0] A_LID   = 15'h452;
  localparam logic [14:0] A_SCRL  = 15'h453;
  localparam logic [14:0] A_F     = 15'h454;
  localparam logic [14:0] A_K     = 15'h455;
  localparam logic [14:0] A_M     = 15'h456;
  localparam logic [14:0] A_N     = 15'h457;
  localparam logic [14:0] A_NP    = 15'h458;
  localparam logic [14:0] A_S     = 15'h459;
  localparam logic [14:0] A_HD    = 15'h45a;
  localparam logic [14:0] A_CSUM  = 15'h45d;
  localparam logic [14:0] A_DSKW  = 15'h46c;
  localparam logic [14:0] A_FPL   = 15'h476;
  localparam logic [14:0] A_LNEN  = 15'h47d;
  // Lane status, read only
  localparam logic [14:0] A_CGS   = 15'h470;
  localparam logic [14:0] A_FSYN  = 15'h471;
  localparam logic [14:0] A_CKS   = 15'h472;
  localparam logic [14:0] A_ILAS  = 15'h473;

  localparam logic [7:0] RST_VAL = 8'h00;

  // Field positions
  localparam int SRST_LO  = 0;
  localparam int SRST_HI  = 7;
  localparam int ADDRINC  = 2;
  localparam int SDO_ACT  = 3;
  localparam int PLL_EN   = 4;
  localparam int PLL_LOCK = 1;
  localparam int SPL_EN   = 0;
  localparam int SPL_LOCK = 0;
  localparam int TEMP_EN  = 0;
  localparam int TEMP_CAP = 0;
  localparam int LNK_PAGE = 2;
  localparam int LNK_DUAL = 3;

  localparam int NCFG = 17;
  localparam int NLNK = 15;

  // Index of a directly mapped register, -1 if none
  function automatic int cfg_idx(input logic [14:0] a);
    case (a)
      A_IFCFG: return 0;
      A_PWR:   return 1;
      A_CLKPD: return 2;
      A_SREF:  return 3;
      A_PLLEN: return 4;
      A_FBCNT: return 5;
      A_VCODV: return 6;
      A_REFDV: return 7;
      A_FMT:   return 8;
      A_INTP:  return 9;
      A_TEN:   return 10;
      A_TCAP:  return 11;
      A_SIPD:  return 12;
      A_LNPD:  return 13;
      A_SPLEN: return 14;
      A_LCTL:  return 15;
      default: return -1;
    endcase
  endfunction : cfg_idx

  // Index of a paged link register, -1 if none
  function automatic int lnk_idx(input logic [14:0] a);
    case (a)
      A_DID:   return 0;
      A_BID:   return 1;
      A_LID:   return 2;
      A_SCRL:  return 3;
      A_F:     return 4;
      A_K:     return 5;
      A_M:     return 6;
      A_N:     return 7;
      A_NP:    return 8;
      A_S:     return 9;
      A_HD:    return 10;
      A_CSUM:  return 11;
      A_DSKW:  return 12;
      A_FPL:   return 13;
      A_LNEN:  return 14;
      default: return -1;
    endcase
  endfunction : lnk_idx

endpackage : dls_pkg

// File: core/dls_spi_slave.sv
// Serial register port engine: instruction, address and streamed data bytes
module dls_spi_slave (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        sclk,
  input  wire logic        csb_n,
  input  wire logic        sdi,
  input  wire logic        incr,
  input  wire logic [7:0]  rdata,
  output logic             wr_stb,
  output logic [14:0]      addr,
  output logic [7:0]       wdata,
  output logic             rd_act,
  output logic             tx_bit
);
  logic        sclk_q_r;
  logic        inst_r;
  logic        rd_r;
  logic        load_r;
  logic [4:0]  cnt_r;
  logic [15:0] sh_r;
  logic [7:0]  tx_r;
  logic        rise;
  logic        fall;

  // Clock edges seen at core rate
  assign rise   = sclk & ~sclk_q_r & ~csb_n;
  assign fall   = ~sclk & sclk_q_r & ~csb_n;
  assign rd_act = ~csb_n & rd_r & ~inst_r;
  assign tx_bit = tx_r[7];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) sclk_q_r <= 1'b0;
    else sclk_q_r <= sclk;
  end

  // Frame sequencing, shifting and address stepping
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      inst_r <= 1'b1;
      rd_r   <= 1'b0;
      load_r <= 1'b0;
      cnt_r  <= 5'h00;
      sh_r   <= 16'h0000;
      tx_r   <= 8'h00;
      addr   <= 15'h0000;
      wdata  <= 8'h00;
      wr_stb <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      load_r <= 1'b0;
      if (wr_stb) addr <= incr ? addr + 15'h0001 : addr - 15'h0001;
      if (csb_n) begin
        inst_r <= 1'b1;
        rd_r   <= 1'b0;
        cnt_r  <= 5'h00;
      end else begin
        if (rise) begin
          sh_r <= {sh_r[14:0], sdi};
          if (inst_r && cnt_r == 5'(dls_pkg::INST_BITS - 1)) begin
            inst_r <= 1'b0;
            cnt_r  <= 5'h00;
            rd_r   <= sh_r[dls_pkg::RW_POS];
            addr   <= {sh_r[13:0], sdi};
            load_r <= sh_r[dls_pkg::RW_POS];
          end else if (!inst_r && cnt_r == 5'(dls_pkg::BYTE_BITS - 1)) begin
            cnt_r <= 5'h00;
            if (rd_r) begin
              addr   <= incr ? addr + 15'h0001 : addr - 15'h0001;
              load_r <= 1'b1;
            end else begin
              wr_stb <= 1'b1;
              wdata  <= {sh_r[6:0], sdi};
            end
          end else begin
            cnt_r <= cnt_r + 5'h01;
          end
        end
        // No shift at a byte boundary, the next byte is loaded instead
        if (fall && !inst_r && cnt_r != 5'h00) tx_r <= {tx_r[6:0], 1'b0};
        if (load_r) tx_r <= rdata;
      end
    end
  end

endmodule : dls_spi_slave

// File: core/dls_temp_capture.sv
// Die temperature code holding register, loaded on a capture request
module dls_temp_capture (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        srst,
  input  wire logic        enable,
  input  wire logic        capture,
  input  wire logic [15:0] code_i,
  output logic [15:0]      code_r
);
  // Capture only while the sensor is on
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) code_r <= 16'h0000;
    else if (srst) code_r <= 16'h0000;
    else if (capture && enable) code_r <= code_i;
  end

endmodule : dls_temp_capture

// File: core/dls_top.sv
// Startup configuration register block with serial port, status and temperature readout
module dls_top (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        sclk,
  input  wire logic        csb_n,
  input  wire logic        sdio_i,
  output logic             sdio_o,
  output logic             sdio_oe,
  output logic             sdo_o,
  output logic             sdo_oe,
  input  wire logic        dac_pll_lock_i,
  input  wire logic        serdes_pll_lock_i,
  input  wire logic [15:0] temp_code_i,
  input  wire logic [7:0]  lane_cgs_i,
  input  wire logic [7:0]  lane_fsync_i,
  input  wire logic [7:0]  lane_cksum_i,
  input  wire logic [7:0]  lane_ilas_i,
  input  wire logic [14:0] cfg_addr_i,
  output logic [7:0]       cfg_data_o,
  output logic             soft_reset_o,
  output logic             four_wire_o,
  output logic             dac_pll_en_o,
  output logic             serdes_pll_en_o,
  output logic             temp_en_o,
  output logic             dual_link_o,
  output logic             link_page_o
);
  logic [7:0]  cfg_r [dls_pkg::NCFG];
  logic [7:0]  lnk_r [2][dls_pkg::NLNK];
  logic        srst_r;
  logic        wr_stb;
  logic [14:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        rd_act;
  logic        tx_bit;
  logic        incr;
  logic        tcap;
  logic [15:0] tcode;
  logic        srst_wr;
  int          wci;
  int          wli;

  // Frequently used control bits
  assign four_wire_o     = cfg_r[0][dls_pkg::SDO_ACT];
  assign incr            = cfg_r[0][dls_pkg::ADDRINC];
  assign dac_pll_en_o    = cfg_r[4][dls_pkg::PLL_EN];
  assign temp_en_o       = cfg_r[10][dls_pkg::TEMP_EN];
  assign serdes_pll_en_o = cfg_r[14][dls_pkg::SPL_EN];
  assign dual_link_o     = cfg_r[15][dls_pkg::LNK_DUAL];
  assign link_page_o     = cfg_r[15][dls_pkg::LNK_PAGE];
  assign soft_reset_o    = srst_r;

  // Serial port engine
  dls_spi_slave u_spi (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .sclk     (sclk),
    .csb_n    (csb_n),
    .sdi      (sdio_i),
    .incr     (incr),
    .rdata    (rdata),
    .wr_stb   (wr_stb),
    .addr     (addr),
    .wdata    (wdata),
    .rd_act   (rd_act),
    .tx_bit   (tx_bit)
  );

  // Readback on sdo in four-wire mode, else on sdio
  assign sdo_o   = tx_bit;
  assign sdio_o  = tx_bit;
  assign sdo_oe  = rd_act & four_wire_o;
  assign sdio_oe = rd_act & ~four_wire_o;

  // Write decode
  assign wci     = dls_pkg::cfg_idx(addr);
  assign wli     = dls_pkg::lnk_idx(addr);
  assign srst_wr = wr_stb && addr == dls_pkg::A_IFCFG &&
                   (wdata[dls_pkg::SRST_LO] || wdata[dls_pkg::SRST_HI]);
  assign tcap    = wr_stb && addr == dls_pkg::A_TCAP && wdata[dls_pkg::TEMP_CAP];

  // Soft reset pulse, one cycle after the write
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) srst_r <= 1'b0;
    else srst_r <= srst_wr;
  end

  // Directly mapped register storage; reset bits self-clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < dls_pkg::NCFG; i++) cfg_r[i] <= dls_pkg::RST_VAL;
    end else if (srst_r) begin
      for (int i = 0; i < dls_pkg::NCFG; i++) cfg_r[i] <= dls_pkg::RST_VAL;
    end else if (wr_stb && wci >= 0) begin
      if (wci == 0) begin
        cfg_r[0] <= wdata & ~(8'h01 << dls_pkg::SRST_LO)
                          & ~(8'h01 << dls_pkg::SRST_HI);
      end else begin
        cfg_r[wci] <= wdata;
      end
    end
  end

  // Paged link parameter storage, page chosen by link control
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < 2; p++)
        for (int i = 0; i < dls_pkg::NLNK; i++) lnk_r[p][i] <= dls_pkg::RST_VAL;
    end else if (srst_r) begin
      for (int p = 0; p < 2; p++)
        for (int i = 0; i < dls_pkg::NLNK; i++) lnk_r[p][i] <= dls_pkg::RST_VAL;
    end else if (wr_stb && wli >= 0) begin
      lnk_r[link_page_o][wli] <= wdata;
    end
  end

  // Temperature code holding register
  dls_temp_capture u_temp (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .srst     (srst_r),
    .enable   (temp_en_o),
    .capture  (tcap),
    .code_i   (temp_code_i),
    .code_r   (tcode)
  );

  // Read value of any address; unmapped reads as zero
  function automatic logic [7:0] rd_val(input logic [14:0] a);
    int ci;
    int li;
    ci = dls_pkg::cfg_idx(a);
    li = dls_pkg::lnk_idx(a);
    if (ci >= 0) return cfg_r[ci];
    if (li >= 0) return lnk_r[link_page_o][li];
    case (a)
      dls_pkg::A_PLLST:
        return 8'(dac_pll_en_o & dac_pll_lock_i) << dls_pkg::PLL_LOCK;
      dls_pkg::A_SPLST:
        return 8'(serdes_pll_en_o & serdes_pll_lock_i) << dls_pkg::SPL_LOCK;
      dls_pkg::A_TLO:  return tcode[7:0];
      dls_pkg::A_THI:  return tcode[15:8];
      dls_pkg::A_CGS:  return lane_cgs_i;
      dls_pkg::A_FSYN: return lane_fsync_i;
      dls_pkg::A_CKS:  return lane_cksum_i;
      dls_pkg::A_ILAS: return lane_ilas_i;
      default:         return 8'h00;
    endcase
  endfunction : rd_val

  // Serial readback source
  always_comb begin
    rdata = rd_val(addr);
  end

  // Internal configuration port, registered
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) cfg_data_o <= 8'h00;
    else cfg_data_o <= rd_val(cfg_addr_i);
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  property p_srst_pulse;
    srst_wr |=> soft_reset_o ##1 !soft_reset_o;
  endproperty
  a_srst_pulse: assert property (p_srst_pulse)
    else $error("soft reset pulse missing");

  property p_srst_clears;
    soft_reset_o |=> !four_wire_o && !dac_pll_en_o && !link_page_o;
  endproperty
  a_srst_clears: assert property (p_srst_clears)
    else $error("soft reset left control bits set");

  property p_four_wire;
    (wr_stb && addr == dls_pkg::A_IFCFG && !srst_wr && wdata[dls_pkg::SDO_ACT])
      |=> four_wire_o ##1 four_wire_o;
  endproperty
  a_four_wire: assert property (p_four_wire)
    else $error("four-wire select not honoured");

  property p_sdo_route;
    rd_act |-> (sdo_oe == four_wire_o) && (sdio_oe == !four_wire_o);
  endproperty
  a_sdo_route: assert property (p_sdo_route)
    else $error("readback pin routing wrong");

  property p_pll_lock;
    cfg_addr_i == dls_pkg::A_PLLST
      |=> cfg_data_o[dls_pkg::PLL_LOCK] == $past(dac_pll_lock_i && dac_pll_en_o);
  endproperty
  a_pll_lock: assert property (p_pll_lock)
    else $error("PLL lock status wrong");

  property p_serdes_lock;
    cfg_addr_i == dls_pkg::A_SPLST
      |=> cfg_data_o[dls_pkg::SPL_LOCK] == $past(serdes_pll_lock_i && serdes_pll_en_o);
  endproperty
  a_serdes_lock: assert property (p_serdes_lock)
    else $error("SERDES PLL lock status wrong");

  property p_temp_cap;
    (tcap && temp_en_o && !srst_r) |=> tcode == $past(temp_code_i);
  endproperty
  a_temp_cap: assert property (p_temp_cap)
    else $error("temperature code not captured");

  property p_temp_hold;
    (!tcap && !srst_r) |=> $stable(tcode);
  endproperty
  a_temp_hold: assert property (p_temp_hold)
    else $error("temperature code changed without capture");

  property p_page_guard;
    (wr_stb && wli >= 0 && link_page_o && !srst_r)
      |=> lnk_r[0][$past(wli)] == $past(lnk_r[0][wli]);
  endproperty
  a_page_guard: assert property (p_page_guard)
    else $error("link page one write hit page zero");

  property p_lane_status;
    cfg_addr_i == dls_pkg::A_CGS |=> cfg_data_o == $past(lane_cgs_i);
  endproperty
  a_lane_status: assert property (p_lane_status)
    else $error("lane sync status wrong");

  property p_lane_fsync;
    cfg_addr_i == dls_pkg::A_FSYN |=> cfg_data_o == $past(lane_fsync_i);
  endproperty
  a_lane_fsync: assert property (p_lane_fsync)
    else $error("frame sync status wrong");

  property p_lane_cksum;
    cfg_addr_i == dls_pkg::A_CKS |=> cfg_data_o == $past(lane_cksum_i);
  endproperty
  a_lane_cksum: assert property (p_lane_cksum)
    else $error("checksum status wrong");

  property p_lane_ilas;
    cfg_addr_i == dls_pkg::A_ILAS |=> cfg_data_o == $past(lane_ilas_i);
  endproperty
  a_lane_ilas: assert property (p_lane_ilas)
    else $error("lane alignment status wrong");

  property p_ifcfg_selfclr;
    (wr_stb && addr == dls_pkg::A_IFCFG && !srst_r)
      |=> !cfg_r[0][dls_pkg::SRST_LO] && !cfg_r[0][dls_pkg::SRST_HI];
  endproperty
  a_ifcfg_selfclr: assert property (p_ifcfg_selfclr)
    else $error("soft reset bits did not self-clear");

  property p_srst_temp;
    soft_reset_o |=> tcode == 16'h0000 && lnk_r[0][0] == dls_pkg::RST_VAL;
  endproperty
  a_srst_temp: assert property (p_srst_temp)
    else $error("soft reset left temperature or link state");

  property p_temp_refuse;
    (tcap && !temp_en_o && !srst_r) |=> $stable(tcode);
  endproperty
  a_temp_refuse: assert property (p_temp_refuse)
    else $error("capture taken while sensor off");

  property p_page_write;
    (wr_stb && wli >= 0 && !srst_r)
      |=> lnk_r[$past(link_page_o)][$past(wli)] == $past(wdata);
  endproperty
  a_page_write: assert property (p_page_write)
    else $error("link register write missed its page");

  property p_link_ctrl;
    (wr_stb && addr == dls_pkg::A_LCTL && !srst_r)
      |=> dual_link_o == $past(wdata[dls_pkg::LNK_DUAL]) &&
          link_page_o == $past(wdata[dls_pkg::LNK_PAGE]);
  endproperty
  a_link_ctrl: assert property (p_link_ctrl)
    else $error("link control bits not honoured");

  property p_pll_en;
    (wr_stb && addr == dls_pkg::A_PLLEN && !srst_r)
      |=> dac_pll_en_o == $past(wdata[dls_pkg::PLL_EN]);
  endproperty
  a_pll_en: assert property (p_pll_en)
    else $error("PLL enable not honoured");

  property p_serdes_en;
    (wr_stb && addr == dls_pkg::A_SPLEN && !srst_r)
      |=> serdes_pll_en_o == $past(wdata[dls_pkg::SPL_EN]);
  endproperty
  a_serdes_en: assert property (p_serdes_en)
    else $error("SERDES PLL enable not honoured");

  property p_temp_en;
    (wr_stb && addr == dls_pkg::A_TEN && !srst_r)
      |=> temp_en_o == $past(wdata[dls_pkg::TEMP_EN]);
  endproperty
  a_temp_en: assert property (p_temp_en)
    else $error("sensor enable not honoured");

  property p_wr_lands;
    (wr_stb && wci > 0 && !srst_r) |=> cfg_r[$past(wci)] == $past(wdata);
  endproperty
  a_wr_lands: assert property (p_wr_lands)
    else $error("register write did not land");

  property p_oe_idle;
    csb_n |-> !sdio_oe && !sdo_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("readback pin driven while deselected");

  c_srst:   cover property (srst_wr ##1 soft_reset_o);
  c_lock:   cover property (cfg_addr_i == dls_pkg::A_PLLST ##1 cfg_data_o[dls_pkg::PLL_LOCK]);
  c_tcap:   cover property (tcap && temp_en_o);
  c_page1:  cover property (wr_stb && wli >= 0 && link_page_o);
  c_rd4w:   cover property (rd_act && four_wire_o);

endmodule : dls_top

// File: dv/dls_spi_host.sv
// Host model driving the serial register port of the startup block
module dls_spi_host (
  input  wire logic  core_clk,
  input  wire logic  sdio_o,
  input  wire logic  sdio_oe,
  input  wire logic  sdo_o,
  input  wire logic  sdo_oe,
  output logic       sclk,
  output logic       csb_n,
  output logic       sdio_i,
  output logic       rd_done,
  output logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic drv = 1'b0;

  // Wire level: device while it drives, else host, which toggles once released
  assign sdio_i = sdio_oe ? sdio_o : drv;

  initial begin
    sclk = 1'b0;
    csb_n = 1'b1;
    rd_done = 1'b0;
    rd_data = 8'h00;
  end

  // Serial clock half period, above the three-cycle minimum
  task automatic half();
    repeat (4) @(negedge core_clk);
  endtask : half

  // One frame, instruction then one byte, MSB first; rep reports a read
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd,
                      input logic rep);
    logic [23:0] f;
    logic [7:0]  q;
    f = {rd, a, wd};
    q = 8'h00;
    csb_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      drv = (rd && i < 8) ? ~drv : f[i];
      half();
      // Sample just before the rise; the next byte loads soon after the last rise
      if (rd && i < 8) q = {q[6:0], sdo_oe ? sdo_o : sdio_i};
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    half();
    csb_n = 1'b1;
    rd_data = q;
    rd_done = rd & rep;
    @(negedge core_clk);
    rd_done = 1'b0;
    half();
  endtask : xfer

  // Bounded status poll, ok stays low if the bits never show
  task automatic poll(input logic [14:0] a, input logic [7:0] m, output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 8 && !ok; n++) begin
      xfer(1'b1, a, 8'h00, 1'b0);
      ok = ((rd_data & m) === m);
    end
  endtask : poll
endmodule : dls_spi_host

// File: dv/dls_top_tb.sv
// Self-checking bench for the startup configuration block
module dls_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    string      name;
    logic [7:0] exp;
  } dls_note_t;

  dls_note_t   notes[$];
  int          num_errors = 0;
  int          compares = 0;
  int          seed = 7;
  int          srst_cnt = 0;
  logic        ok;
  logic [15:0] code;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        sclk, csb_n, sdio_i, sdio_o, sdio_oe, sdo_o, sdo_oe, rd_done;
  logic [7:0]  rd_data, cfg_data_o;
  logic        dac_pll_lock_i = 1'b0;
  logic        serdes_pll_lock_i = 1'b0;
  logic [15:0] temp_code_i = 16'h0000;
  logic [7:0]  lane_cgs_i = 8'h00, lane_fsync_i = 8'h00;
  logic [7:0]  lane_cksum_i = 8'h00, lane_ilas_i = 8'h00;
  logic [14:0] cfg_addr_i = 15'h0000;
  logic        soft_reset_o, four_wire_o, dac_pll_en_o, serdes_pll_en_o;
  logic        temp_en_o, dual_link_o, link_page_o;

  // Host startup writes: address, value, readback (zero where unmapped)
  logic [27:0] seq [0:28] = '{
    28'h011_28_28, 28'h080_00_00, 28'h081_00_00,
    28'h12d_8b_00, 28'h2a4_ff_00, 28'h333_01_00,
    28'h08b_02_02, 28'h08c_03_03, 28'h085_10_10,
    28'h1b5_80_00, 28'h112_00_00, 28'h110_00_00,
    28'h200_00_00, 28'h201_00_00, 28'h300_08_08,
    28'h450_00_00, 28'h451_00_00, 28'h452_00_00,
    28'h453_83_83, 28'h455_1f_1f, 28'h456_00_00,
    28'h457_0f_0f, 28'h458_2f_2f, 28'h459_20_20,
    28'h45a_80_80, 28'h476_01_01, 28'h45d_45_45,
    28'h46c_ff_ff, 28'h47d_ff_ff};

  always #4 core_clk = ~core_clk;

  dls_top i_dut (.core_clk(core_clk), .arst_n(arst_n), .sclk(sclk), .csb_n(csb_n),
    .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .dac_pll_lock_i(dac_pll_lock_i), .serdes_pll_lock_i(serdes_pll_lock_i),
    .temp_code_i(temp_code_i), .lane_cgs_i(lane_cgs_i), .lane_fsync_i(lane_fsync_i),
    .lane_cksum_i(lane_cksum_i), .lane_ilas_i(lane_ilas_i), .cfg_addr_i(cfg_addr_i),
    .cfg_data_o(cfg_data_o), .soft_reset_o(soft_reset_o), .four_wire_o(four_wire_o),
    .dac_pll_en_o(dac_pll_en_o), .serdes_pll_en_o(serdes_pll_en_o),
    .temp_en_o(temp_en_o), .dual_link_o(dual_link_o), .link_page_o(link_page_o));

  dls_spi_host i_host (.core_clk(core_clk), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .sclk(sclk), .csb_n(csb_n), .sdio_i(sdio_i),
    .rd_done(rd_done), .rd_data(rd_data));

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [14:0] a, input logic [7:0] v);
    i_host.xfer(1'b0, a, v, 1'b0);
  endtask : wr

  // Internal port: set address, wait two cycles, compare
  task automatic cfg_chk(input string nm, input logic [14:0] a, input logic [7:0] e);
    cfg_addr_i = a;
    repeat (2) @(negedge core_clk);
    chk(nm, e, cfg_data_o);
  endtask : cfg_chk

  // Note the expected byte, then read it back
  task automatic rd(input string nm, input logic [14:0] a, input logic [7:0] e);
    notes.push_back('{nm, e});
    i_host.xfer(1'b1, a, 8'h00, 1'b1);
  endtask : rd

  task automatic done(input string nm);
    $display("test %s finished, %0d mismatches so far", nm, num_errors);
  endtask : done

  task automatic results();
    $display("comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // Readback scoreboard and soft reset pulse counter
  always @(posedge core_clk) begin
    if (rd_done === 1'b1) begin
      if (notes.size() == 0) begin
        chk("unnoted read", 8'hxx, rd_data);
      end else begin
        chk(notes[0].name, notes[0].exp, rd_data);
        notes.delete(0);
      end
    end
    if (soft_reset_o === 1'b1) srst_cnt++;
  end

  // Cycle limit against a hang
  initial begin
    repeat (100000) @(posedge core_clk);
    chk("cycle limit", 8'h00, 8'h01);
    results();
  end

  initial begin
    repeat (4) @(negedge core_clk);
    chk("outputs in reset", 8'h00, {1'b0, sdio_oe, sdo_oe, soft_reset_o, four_wire_o,
        dac_pll_en_o, temp_en_o, link_page_o});
    arst_n = 1'b1;
    // Soft reset clears registers, third write picks four-wire
    rd("power at reset", dls_pkg::A_PWR, 8'h00);
    wr(dls_pkg::A_PWR, 8'h28);
    wr(dls_pkg::A_IFCFG, 8'hbd);
    chk("soft reset pulses", 8'h01, 8'(srst_cnt));
    rd("power after soft reset", dls_pkg::A_PWR, 8'h00);
    rd("ifcfg after soft reset", dls_pkg::A_IFCFG, 8'h00);
    wr(dls_pkg::A_IFCFG, 8'h3c);
    chk("four wire out", 8'h01, {7'h00, four_wire_o});
    rd("ifcfg four wire", dls_pkg::A_IFCFG, 8'h3c);
    done("soft reset");
    // Phased startup; link bring-up past this is quick-start only
    for (int i = 0; i < 29; i++) begin
      wr(15'(seq[i][27:16]), seq[i][15:8]);
      rd($sformatf("reg %h", seq[i][27:16]), 15'(seq[i][27:16]), seq[i][7:0]);
    end
    chk("dual link out", 8'h01, {7'h00, dual_link_o});
    done("startup");
    // PLL status needs both enable and lock
    dac_pll_lock_i = 1'b1;
    rd("pll status disabled", dls_pkg::A_PLLST, 8'h00);
    wr(dls_pkg::A_PLLEN, 8'h10);
    dac_pll_lock_i = 1'b0;
    rd("pll status unlocked", dls_pkg::A_PLLST, 8'h00);
    dac_pll_lock_i = 1'b1;
    i_host.poll(dls_pkg::A_PLLST, 8'h02, ok);
    chk("pll lock and enable", 8'h03, {6'h00, ok, dac_pll_en_o});
    serdes_pll_lock_i = 1'b1;
    rd("serdes status disabled", dls_pkg::A_SPLST, 8'h00);
    wr(dls_pkg::A_SPLEN, 8'h01);
    serdes_pll_lock_i = 1'b0;
    rd("serdes status unlocked", dls_pkg::A_SPLST, 8'h00);
    serdes_pll_lock_i = 1'b1;
    i_host.poll(dls_pkg::A_SPLST, 8'h01, ok);
    chk("serdes lock and enable", 8'h03, {6'h00, ok, serdes_pll_en_o});
    done("pll");
    // Lane status registers follow the lane flags
    for (int k = 0; k < 3; k++) begin
      lane_cgs_i = (k == 2) ? 8'hff : 8'($random(seed));
      lane_fsync_i = (k == 2) ? 8'hff : 8'($random(seed));
      lane_cksum_i = (k == 2) ? 8'hff : 8'($random(seed));
      lane_ilas_i = (k == 2) ? 8'hff : 8'($random(seed));
      rd("code group sync", dls_pkg::A_CGS, lane_cgs_i);
      rd("frame sync", dls_pkg::A_FSYN, lane_fsync_i);
      rd("checksum status", dls_pkg::A_CKS, lane_cksum_i);
      rd("lane alignment", dls_pkg::A_ILAS, lane_ilas_i);
    end
    done("lane status");
    // Temperature capture refused while off, then one capture feeds both bytes
    temp_code_i = 16'($random(seed));
    wr(dls_pkg::A_TCAP, 8'h01);
    rd("temp low refused", dls_pkg::A_TLO, 8'h00);
    wr(dls_pkg::A_TEN, 8'h01);
    chk("temp enable out", 8'h01, {7'h00, temp_en_o});
    code = temp_code_i;
    wr(dls_pkg::A_TCAP, 8'h01);
    temp_code_i = ~code;
    rd("temp low", dls_pkg::A_TLO, code[7:0]);
    rd("temp high", dls_pkg::A_THI, code[15:8]);
    done("temperature");
    // Link page select keeps the two pages apart
    wr(dls_pkg::A_LCTL, 8'h04);
    chk("page out", 8'h01, {7'h00, link_page_o});
    wr(dls_pkg::A_DID, 8'h5a);
    rd("page one device id", dls_pkg::A_DID, 8'h5a);
    wr(dls_pkg::A_LCTL, 8'h00);
    rd("page zero device id", dls_pkg::A_DID, 8'h00);
    chk("single link out", 8'h00, {7'h00, dual_link_o});
    done("link page");
    // Configuration read port, status sources included
    lane_cgs_i = 8'($random(seed));
    lane_fsync_i = 8'($random(seed));
    lane_cksum_i = 8'($random(seed));
    lane_ilas_i = 8'($random(seed));
    cfg_chk("config port", dls_pkg::A_PWR, 8'h28);
    cfg_chk("config pll status", dls_pkg::A_PLLST, 8'h02);
    cfg_chk("config serdes status", dls_pkg::A_SPLST, 8'h01);
    cfg_chk("config code group sync", dls_pkg::A_CGS, lane_cgs_i);
    cfg_chk("config frame sync", dls_pkg::A_FSYN, lane_fsync_i);
    cfg_chk("config checksum", dls_pkg::A_CKS, lane_cksum_i);
    cfg_chk("config lane alignment", dls_pkg::A_ILAS, lane_ilas_i);
    done("config port");
    chk("notes left", 8'h00, 8'(notes.size()));
    results();
  end
endmodule : dls_top_tb
